// [design/rvr_rail_reference_vid_regs.sv]
// Rail 1 reference, clamp and alert-mask register bank
`timescale 1ns/1ps
`default_nettype none

module rvr_rail_reference_vid_regs (
  input wire logic mclk, // 10 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic [7:0] cmdCode, // Register command code
  input wire logic wrEn, // Write strobe, one cycle
  input wire logic [15:0] wrData, // Write data word
  input wire logic rdEn, // Read strobe, one cycle
  output logic [15:0] rdData, // Read data, held until next read
  output logic rdValid, // Read data valid pulse
  input wire rvr_pkg::rvr_alert_src_t alertSrc, // Fault sources, asynchronous
  input wire logic alertPinFunctionSelect, // 0: pin is the alert
  input wire logic [1:0] reportFormatSel, // Report format select
  input wire logic vidRes10mV, // Rail VID resolution select
  input wire logic diffHalfGain, // Sense amplifier half gain
  input wire logic extDividerEn, // External divider fitted
  input wire rvr_pkg::rvr_mode_t railMode, // Active VID interface mode
  input wire rvr_pkg::rvr_margin_t marginSel, // Operation margin choice
  input wire logic [8:0] serialVid, // VID from serial VID bus
  input wire logic [8:0] parallelVid, // VID from parallel VID pins
  input wire logic [8:0] avsVid, // VID from AVS bus
  output logic alertPinN, // Alert pin, active low
  output logic [8:0] railRefVid, // Final rail reference VID
  output rvr_pkg::rvr_cfg_t railCfg // Loop and sense settings
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] maskReg, maskNext;
  logic [15:0] targetReg, targetNext;
  logic [15:0] trimReg, trimNext;
  logic [15:0] offsetReg, offsetNext;
  logic [15:0] ceilReg, ceilNext;
  logic [15:0] upperReg, upperNext;
  logic [15:0] lowerReg, lowerNext;
  logic [15:0] slewReg, slewNext;
  logic [15:0] droopReg, droopNext;
  logic [15:0] senseReg, senseNext;
  logic [15:0] floorReg, floorNext;
  logic [15:0] rdDataReg, rdDataNext;
  logic rdValidReg, rdValidNext;
  logic [7:0] reportFmt;

  // Report format byte from the select field
  always_comb begin
    if (reportFormatSel[1]) begin
      reportFmt = rvr_pkg::FMT_DIRECT;
    end else if (reportFormatSel[0]) begin
      reportFmt = rvr_pkg::FMT_LINEAR;
    end else begin
      reportFmt = rvr_pkg::FMT_VID;
    end
  end

  // Write decode; unused bits are masked off before storing
  always_comb begin
    maskNext = maskReg;
    targetNext = targetReg;
    trimNext = trimReg;
    offsetNext = offsetReg;
    ceilNext = ceilReg;
    upperNext = upperReg;
    lowerNext = lowerReg;
    slewNext = slewReg;
    droopNext = droopReg;
    senseNext = senseReg;
    floorNext = floorReg;
    if (wrEn) begin
      case (cmdCode)
        rvr_pkg::ADDR_ALERT_MASK: maskNext = wrData & rvr_pkg::MASK_RW_BITS;
        rvr_pkg::ADDR_TARGET_VID: targetNext = wrData & rvr_pkg::VID9_RW_BITS;
        rvr_pkg::ADDR_FINE_ADJUST: trimNext = wrData & rvr_pkg::SEVEN_RW_BITS;
        rvr_pkg::ADDR_REF_OFFSET: offsetNext = wrData & rvr_pkg::BYTE_RW_BITS;
        rvr_pkg::ADDR_CEILING_VID: ceilNext = wrData & rvr_pkg::VID9_RW_BITS;
        rvr_pkg::ADDR_UPPER_MARGIN: upperNext = wrData & rvr_pkg::VID9_RW_BITS;
        rvr_pkg::ADDR_LOWER_MARGIN: lowerNext = wrData & rvr_pkg::VID9_RW_BITS;
        rvr_pkg::ADDR_TRANS_SLEW: slewNext = wrData & rvr_pkg::SEVEN_RW_BITS;
        rvr_pkg::ADDR_DROOP_GAIN: droopNext = wrData & rvr_pkg::BYTE_RW_BITS;
        rvr_pkg::ADDR_SENSE_OPTS: senseNext = wrData & rvr_pkg::SENSE_RW_BITS;
        rvr_pkg::ADDR_FLOOR_VID: floorNext = wrData & rvr_pkg::VID9_RW_BITS;
        default: ; // Read-only or unmapped: write ignored
      endcase
    end
  end

  // Read mux; answer lands one cycle after the strobe
  always_comb begin
    rdDataNext = rdDataReg;
    rdValidNext = rdEn;
    if (rdEn) begin
      case (cmdCode)
        rvr_pkg::ADDR_ALERT_MASK: rdDataNext = maskReg;
        rvr_pkg::ADDR_REPORT_FMT: rdDataNext = {8'h00, reportFmt};
        rvr_pkg::ADDR_TARGET_VID: rdDataNext = targetReg;
        rvr_pkg::ADDR_FINE_ADJUST: rdDataNext = trimReg;
        rvr_pkg::ADDR_REF_OFFSET: rdDataNext = offsetReg;
        rvr_pkg::ADDR_CEILING_VID: rdDataNext = ceilReg;
        rvr_pkg::ADDR_UPPER_MARGIN: rdDataNext = upperReg;
        rvr_pkg::ADDR_LOWER_MARGIN: rdDataNext = lowerReg;
        rvr_pkg::ADDR_TRANS_SLEW: rdDataNext = slewReg;
        rvr_pkg::ADDR_DROOP_GAIN: rdDataNext = droopReg;
        rvr_pkg::ADDR_SENSE_OPTS: rdDataNext = senseReg;
        rvr_pkg::ADDR_FLOOR_VID: rdDataNext = floorReg;
        default: rdDataNext = 16'h0000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      maskReg <= rvr_pkg::RST_MASK;
      targetReg <= rvr_pkg::RST_TARGET_VID;
      trimReg <= rvr_pkg::RST_ZERO;
      offsetReg <= rvr_pkg::RST_ZERO;
      ceilReg <= rvr_pkg::RST_CEILING_VID;
      upperReg <= rvr_pkg::RST_ZERO;
      lowerReg <= rvr_pkg::RST_ZERO;
      slewReg <= rvr_pkg::RST_ZERO;
      droopReg <= rvr_pkg::RST_ZERO;
      senseReg <= rvr_pkg::RST_ZERO;
      floorReg <= rvr_pkg::RST_FLOOR_VID;
      rdDataReg <= 16'h0000;
      rdValidReg <= 1'b0;
    end else begin
      maskReg <= maskNext;
      targetReg <= targetNext;
      trimReg <= trimNext;
      offsetReg <= offsetNext;
      ceilReg <= ceilNext;
      upperReg <= upperNext;
      lowerReg <= lowerNext;
      slewReg <= slewNext;
      droopReg <= droopNext;
      senseReg <= senseNext;
      floorReg <= floorNext;
      rdDataReg <= rdDataNext;
      rdValidReg <= rdValidNext;
    end
  end

  assign rdData = rdDataReg;
  assign rdValid = rdValidReg;

  ////////////////////////////////////////////////////////////////////////////
  // Alert pin
  rvr_pkg::rvr_alert_src_t srcMeta, srcSync;
  logic alertPinNReg, alertPinNNext;

  // Two-stage synchroniser for the asynchronous fault sources
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srcMeta <= '0;
      srcSync <= '0;
    end else begin
      srcMeta <= alertSrc;
      srcSync <= srcMeta;
    end
  end

  // Unmasked sources pull the pin low
  always_comb begin
    alertPinNNext = 1'b1;
    if (!alertPinFunctionSelect) begin
      // mask bit 0 keeps pin high
      alertPinNNext = !((srcSync.nvmFault && maskReg[rvr_pkg::MASK_NVM_BIT])
                     || (srcSync.inputOvervolt && maskReg[rvr_pkg::MASK_VINOV_BIT])
                     || (srcSync.inputUndervolt && maskReg[rvr_pkg::MASK_VINUV_BIT])
                     || (srcSync.overTemp && maskReg[rvr_pkg::MASK_OT_BIT]));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      alertPinNReg <= 1'b1;
    end else begin
      alertPinNReg <= alertPinNNext;
    end
  end

  assign alertPinN = alertPinNReg;

  ////////////////////////////////////////////////////////////////////////////
  // Reference path
  logic [8:0] srcVid, ceilEff, floorEff, clampedVid;
  logic clampOn;
  logic signed [10:0] refSum;
  logic [8:0] refNext, refReg;
  rvr_pkg::rvr_cfg_t cfgNext, cfgReg;

  // Source selection, margins win over the interface
  always_comb begin
    case (railMode)
      rvr_pkg::MODE_BUS, rvr_pkg::MODE_SERIAL_FIXED: srcVid = targetReg[8:0];
      rvr_pkg::MODE_SERIAL: srcVid = serialVid;
      rvr_pkg::MODE_PARALLEL: srcVid = parallelVid;
      rvr_pkg::MODE_AVS: srcVid = avsVid;
      default: srcVid = targetReg[8:0];
    endcase
    if (marginSel == rvr_pkg::OP_MARGIN_HIGH) begin
      srcVid = upperReg[8:0];
    end else if (marginSel == rvr_pkg::OP_MARGIN_LOW) begin
      srcVid = lowerReg[8:0];
    end
  end

  // Clamps; a zero divider ratio would divide by zero, so it leaves them raw
  always_comb begin
    clampOn = (railMode == rvr_pkg::MODE_BUS) || (railMode == rvr_pkg::MODE_PARALLEL)
           || (railMode == rvr_pkg::MODE_AVS);
    ceilEff = ceilReg[8:0];
    floorEff = floorReg[8:0];
    if (extDividerEn && (senseReg[rvr_pkg::DIV_RATIO_MSB:0] != 9'h000)) begin
      ceilEff = ceilReg[8:0] / senseReg[rvr_pkg::DIV_RATIO_MSB:0];
      floorEff = floorReg[8:0] / senseReg[rvr_pkg::DIV_RATIO_MSB:0];
    end
    clampedVid = srcVid;
    if (clampOn) begin
      if (srcVid > ceilEff) begin
        clampedVid = ceilEff;
      end else if (srcVid < floorEff) begin
        clampedVid = floorEff;
      end
    end
  end

  // Offset last, saturated into the nine-bit VID range
  always_comb begin
    refSum = $signed({2'b00, clampedVid}) + $signed({{3{offsetReg[7]}}, offsetReg[7:0]});
    if (refSum < 0) begin
      refNext = 9'h000;
    end else if (refSum > $signed(rvr_pkg::VID_LIMIT)) begin
      refNext = 9'h1ff;
    end else begin
      refNext = refSum[8:0];
    end
  end

  // Settings handed to the loop; the analog side applies the weights
  always_comb begin
    cfgNext.outputFineAdjust = trimReg[6:0];
    cfgNext.trimHalfGain = diffHalfGain;
    cfgNext.transitionSlew = slewReg[6:0];
    cfgNext.droopGain = droopReg[7:0];
    cfgNext.setSignalSyncSelect = senseReg[rvr_pkg::SYNC_ONCE_BIT];
    cfgNext.setSignalBlockTime = senseReg[rvr_pkg::BLOCK_TIME_MSB:rvr_pkg::BLOCK_TIME_LSB];
    cfgNext.dividerRatio = senseReg[rvr_pkg::DIV_RATIO_MSB:0];
    cfgNext.vidStep10mV = vidRes10mV;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      refReg <= 9'h000;
      cfgReg <= '0;
    end else begin
      refReg <= refNext;
      cfgReg <= cfgNext;
    end
  end

  assign railRefVid = refReg;
  assign railCfg = cfgReg;

endmodule

`default_nettype wire

// [design/rvr_pkg.sv]
// Constants, field layouts and carrier types of the rail 1 reference register bank
`default_nettype none
package rvr_pkg;
  // Command codes of the bank
  localparam logic [7:0] ADDR_ALERT_MASK = 8'h1b;
  localparam logic [7:0] ADDR_REPORT_FMT = 8'h20;
  localparam logic [7:0] ADDR_TARGET_VID = 8'h21;
  localparam logic [7:0] ADDR_FINE_ADJUST = 8'h22;
  localparam logic [7:0] ADDR_REF_OFFSET = 8'h23;
  localparam logic [7:0] ADDR_CEILING_VID = 8'h24;
  localparam logic [7:0] ADDR_UPPER_MARGIN = 8'h25;
  localparam logic [7:0] ADDR_LOWER_MARGIN = 8'h26;
  localparam logic [7:0] ADDR_TRANS_SLEW = 8'h27;
  localparam logic [7:0] ADDR_DROOP_GAIN = 8'h28;
  localparam logic [7:0] ADDR_SENSE_OPTS = 8'h29;
  localparam logic [7:0] ADDR_FLOOR_VID = 8'h2b;
  // Alert mask field positions and writable bits
  localparam int MASK_NVM_BIT = 4;
  localparam int MASK_VINOV_BIT = 3;
  localparam int MASK_VINUV_BIT = 1;
  localparam int MASK_OT_BIT = 0;
  localparam logic [15:0] MASK_RW_BITS = 16'h001b;
  // Writable bits of each word
  localparam logic [15:0] VID9_RW_BITS = 16'h01ff;
  localparam logic [15:0] SEVEN_RW_BITS = 16'h007f;
  localparam logic [15:0] BYTE_RW_BITS = 16'h00ff;
  localparam logic [15:0] SENSE_RW_BITS = 16'h3fff;
  // Sense options field positions
  localparam int SYNC_ONCE_BIT = 13;
  localparam int BLOCK_TIME_MSB = 12;
  localparam int BLOCK_TIME_LSB = 9;
  localparam int DIV_RATIO_MSB = 8;
  // Report format answers
  localparam logic [7:0] FMT_DIRECT = 8'h40;
  localparam logic [7:0] FMT_LINEAR = 8'h18;
  localparam logic [7:0] FMT_VID = 8'h21;
  // Reset values
  localparam logic [15:0] RST_MASK = 16'h001b;
  localparam logic [15:0] RST_TARGET_VID = 16'h0000;
  localparam logic [15:0] RST_CEILING_VID = 16'h01ff;
  localparam logic [15:0] RST_FLOOR_VID = 16'h0000;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  // Reference saturation limit, one VID step per LSB
  localparam logic [10:0] VID_LIMIT = 11'h1ff;

  typedef enum logic [2:0] {MODE_BUS, MODE_SERIAL_FIXED, MODE_SERIAL, MODE_PARALLEL,
    MODE_AVS} rvr_mode_t;
  typedef enum logic [1:0] {OP_NORMAL, OP_MARGIN_LOW, OP_MARGIN_HIGH} rvr_margin_t;

  typedef struct packed {
    logic nvmFault;
    logic inputOvervolt;
    logic inputUndervolt;
    logic overTemp;
  } rvr_alert_src_t;

  typedef struct packed {
    logic [6:0] outputFineAdjust;
    logic trimHalfGain;
    logic [6:0] transitionSlew;
    logic [7:0] droopGain;
    logic setSignalSyncSelect;
    logic [3:0] setSignalBlockTime;
    logic [8:0] dividerRatio;
    logic vidStep10mV;
  } rvr_cfg_t;
endpackage
`default_nettype wire

// [verif/rvr_properties.sv]
// Port-level assertions of the rail reference register bank
`timescale 1ns/1ps
`default_nettype none
module rvr_properties (
  input wire logic mclk, // Clock
  input wire logic resetn, // Reset
  input wire logic [7:0] cmdCode, // Code
  input wire logic wrEn, // Write
  input wire logic [15:0] wrData, // Word
  input wire logic rdEn, // Read
  input wire logic [15:0] rdData, // Answer
  input wire logic rdValid, // Answer valid
  input wire rvr_pkg::rvr_alert_src_t alertSrc, // Sources
  input wire logic alertPinFunctionSelect, // Pin role
  input wire logic [1:0] reportFormatSel, // Format
  input wire logic vidRes10mV, // Step
  input wire logic diffHalfGain, // Gain
  input wire rvr_pkg::rvr_mode_t railMode, // Mode
  input wire rvr_pkg::rvr_margin_t marginSel, // Margin
  input wire logic [8:0] serialVid, // Serial VID
  input wire logic alertPinN, // Alert
  input wire logic [8:0] railRefVid, // Reference
  input wire rvr_pkg::rvr_cfg_t railCfg // Settings
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0] offsetReg, offsetNext;
  // Shadow of the offset register, the only state the reference check needs
  always_comb begin
    offsetNext = offsetReg;
    if (wrEn && cmdCode == rvr_pkg::ADDR_REF_OFFSET) offsetNext = wrData[7:0];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) offsetReg <= 8'h00;
    else offsetReg <= offsetNext;
  end
  function automatic logic [8:0] satAdd(logic [8:0] v, logic [7:0] o);
    int s;
    s = int'(v) + int'($signed(o));
    return (s < 0) ? 9'h000 : (s > 511) ? 9'h1ff : s[8:0];
  endfunction
  function automatic logic [7:0] fmtOf(logic [1:0] sel);
    return sel[1] ? 8'h40 : sel[0] ? 8'h18 : 8'h21;
  endfunction
  a_fmt_read_byte:
    assert property (rdEn && cmdCode == rvr_pkg::ADDR_REPORT_FMT
      |=> rdData == {8'h00, fmtOf($past(reportFormatSel))}) else $error("format byte wrong");
  a_vid_upper_zero:
    assert property (rdEn && cmdCode inside {8'h21, 8'h24, 8'h25, 8'h26, 8'h2b}
      |=> rdData[15:9] == 7'h00) else $error("vid upper bits set");
  a_mask_unused_zero:
    assert property (rdEn && cmdCode == rvr_pkg::ADDR_ALERT_MASK
      |=> (rdData & ~rvr_pkg::MASK_RW_BITS) == 16'h0000) else $error("mask spare bits set");
  a_byte_unused_zero:
    assert property (rdEn && cmdCode inside {8'h23, 8'h28}
      |=> rdData[15:8] == 8'h00) else $error("byte upper bits set");
  a_select_pin_high:
    assert property (alertPinFunctionSelect |=> alertPinN) else $error("pin low off role");
  a_quiet_pin_high:
    assert property ((alertSrc == 4'h0) [*3] |=> alertPinN) else $error("alert without source");
  a_offset_added:
    assert property (railMode == rvr_pkg::MODE_SERIAL && marginSel == rvr_pkg::OP_NORMAL
      |=> railRefVid == satAdd($past(serialVid), $past(offsetReg))) else $error("offset sum");
  a_cfg_copies_step:
    assert property (1'b1 |=> railCfg.vidStep10mV == $past(vidRes10mV)
      && railCfg.trimHalfGain == $past(diffHalfGain)) else $error("step or gain copy");
  a_read_valid_pulse:
    assert property (1'b1 |=> rdValid == $past(rdEn)) else $error("read answer pulse wrong");
  c_read: cover property (rdEn ##1 rdEn);
  c_alert: cover property (!alertPinN);
  c_margin: cover property (marginSel == rvr_pkg::OP_MARGIN_HIGH);
endmodule
bind rvr_rail_reference_vid_regs rvr_properties rvr_properties_i (.mclk, .resetn, .cmdCode,
  .wrEn, .wrData, .rdEn, .rdData, .rdValid, .alertSrc, .alertPinFunctionSelect,
  .reportFormatSel, .vidRes10mV, .diffHalfGain, .railMode, .marginSel, .serialVid, .alertPinN,
  .railRefVid, .railCfg);
`default_nettype wire

// [verif/rvr_host_model.sv]
// Management bus host that issues register reads and writes
`timescale 1ns/1ps
`default_nettype none
module rvr_host_model (
  input wire logic mclk, // Clock
  output logic [7:0] cmdCode, // Code
  output logic wrEn, // Write
  output logic [15:0] wrData, // Word
  output logic rdEn, // Read
  input wire logic [15:0] rdData, // Answer
  input wire logic rdValid // Answer valid
);
  initial begin
    cmdCode = 8'h00;
    wrEn = 1'b0;
    wrData = 16'h0000;
    rdEn = 1'b0;
  end
  // Released fields are inverted so nothing leans on stale values
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    cmdCode = a;
    wrData = d;
    wrEn = 1'b1;
    @(negedge mclk);
    wrEn = 1'b0;
    wrData = ~d;
    cmdCode = ~a;
  endtask
  // Answer stands one cycle after the read edge; no answer gives unknowns
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    cmdCode = a;
    rdEn = 1'b1;
    @(negedge mclk);
    rdEn = 1'b0;
    cmdCode = ~a;
    d = (rdValid === 1'b1) ? rdData : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench of the rail reference register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, resetn, wrEn, rdEn, rdValid, alertPinFunctionSelect, alertPinN;
  logic vidRes10mV, diffHalfGain, extDividerEn;
  logic [7:0] cmdCode;
  logic [15:0] wrData, rdData, word;
  logic [1:0] reportFormatSel;
  logic [8:0] serialVid, parallelVid, avsVid, railRefVid;
  rvr_pkg::rvr_alert_src_t alertSrc;
  rvr_pkg::rvr_mode_t railMode;
  rvr_pkg::rvr_margin_t marginSel;
  rvr_pkg::rvr_cfg_t railCfg;
  int badCount = 0;
  int checked = 0;
  rvr_rail_reference_vid_regs rvr_rail_reference_vid_regs_i (.mclk, .resetn, .cmdCode, .wrEn,
    .wrData, .rdEn, .rdData, .rdValid, .alertSrc, .alertPinFunctionSelect, .reportFormatSel,
    .vidRes10mV, .diffHalfGain, .extDividerEn, .railMode, .marginSel, .serialVid, .parallelVid,
    .avsVid, .alertPinN, .railRefVid, .railCfg);
  rvr_host_model rvr_host_model_i (.mclk, .cmdCode, .wrEn, .wrData, .rdEn, .rdData, .rdValid);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    rvr_host_model_i.rd(a, word);
    chk(word, exp);
  endtask
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Every word written all ones; only writable bits survive, code 20h stays read-only
  task automatic testRegs();
    logic [7:0] adr [13] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
      8'h2b, 8'h1b, 8'h20, 8'h2a};
    logic [15:0] exp [13] = '{16'h01ff, 16'h007f, 16'h00ff, 16'h01ff, 16'h01ff, 16'h01ff,
      16'h007f, 16'h00ff, 16'h3fff, 16'h01ff, 16'h001b, 16'h0021, 16'h0000};
    rdChk(8'h1b, 16'h001b);
    rdChk(8'h24, 16'h01ff);
    rdChk(8'h21, 16'h0000);
    for (int i = 0; i < 13; i++) begin
      rvr_host_model_i.wr(adr[i], 16'hffff);
      rdChk(adr[i], exp[i]);
    end
    chk({1'b0, railCfg.transitionSlew, railCfg.droopGain}, 16'h7fff);
    chk({9'h000, railCfg.outputFineAdjust}, 16'h007f);
    rvr_host_model_i.wr(8'h29, 16'h1402);
    vidRes10mV = 1'b1;
    diffHalfGain = 1'b1;
    @(negedge mclk);
    chk({2'b00, railCfg.setSignalSyncSelect, railCfg.setSignalBlockTime,
      railCfg.dividerRatio}, 16'h1402);
    chk({14'h0000, railCfg.vidStep10mV, railCfg.trimHalfGain}, 16'h0003);
    $display("register test done");
  endtask
  task automatic testFormat();
    for (int i = 0; i < 4; i++) begin
      reportFormatSel = i[1:0];
      rdChk(8'h20, {8'h00, (i > 1) ? 8'h40 : (i == 1) ? 8'h18 : 8'h21});
    end
    $display("format test done");
  endtask
  // Each source alone: masked, unmasked, then pin taken from the alert role
  task automatic testAlert();
    int mb [4] = '{0, 1, 3, 4};
    for (int i = 0; i < 4; i++) begin
      rvr_host_model_i.wr(8'h1b, 16'h001b ^ (16'h0001 << mb[i]));
      alertSrc = 4'h1 << i;
      repeat (4) @(negedge mclk);
      chk(16'(alertPinN), 16'h0001);
      rvr_host_model_i.wr(8'h1b, 16'h001b);
      @(negedge mclk);
      chk(16'(alertPinN), 16'h0000);
      alertPinFunctionSelect = 1'b1;
      @(negedge mclk);
      chk(16'(alertPinN), 16'h0001);
      alertPinFunctionSelect = 1'b0;
      alertSrc = 4'h0;
      repeat (4) @(negedge mclk);
    end
    $display("alert test done");
  endtask
  task automatic refChk(input rvr_pkg::rvr_mode_t m, input rvr_pkg::rvr_margin_t g,
    input logic [8:0] v, input logic [8:0] e);
    railMode = m;
    marginSel = g;
    serialVid = v;
    parallelVid = v;
    avsVid = v;
    @(negedge mclk);
    chk({7'h00, railRefVid}, {7'h00, e});
  endtask
  // Ceiling 100h, floor 10h, offset -1 step: clamp first, then the offset
  task automatic testRef();
    logic [7:0] adr [6] = '{8'h24, 8'h2b, 8'h23, 8'h25, 8'h26, 8'h21};
    logic [15:0] val [6] = '{16'h0100, 16'h0010, 16'h00ff, 16'h0180, 16'h0020, 16'h0150};
    for (int i = 0; i < 6; i++) rvr_host_model_i.wr(adr[i], val[i]);
    refChk(rvr_pkg::MODE_PARALLEL, rvr_pkg::OP_NORMAL, 9'h1f0, 9'h0ff);
    refChk(rvr_pkg::MODE_AVS, rvr_pkg::OP_NORMAL, 9'h005, 9'h00f);
    refChk(rvr_pkg::MODE_PARALLEL, rvr_pkg::OP_MARGIN_HIGH, 9'h005, 9'h0ff);
    refChk(rvr_pkg::MODE_PARALLEL, rvr_pkg::OP_MARGIN_LOW, 9'h005, 9'h01f);
    refChk(rvr_pkg::MODE_SERIAL, rvr_pkg::OP_NORMAL, 9'h1f0, 9'h1ef);
    refChk(rvr_pkg::MODE_BUS, rvr_pkg::OP_NORMAL, 9'h000, 9'h0ff);
    refChk(rvr_pkg::MODE_SERIAL_FIXED, rvr_pkg::OP_NORMAL, 9'h000, 9'h14f);
    rvr_host_model_i.wr(8'h23, 16'h0080);
    refChk(rvr_pkg::MODE_SERIAL, rvr_pkg::OP_NORMAL, 9'h005, 9'h000);
    rvr_host_model_i.wr(8'h23, 16'h0000);
    extDividerEn = 1'b1;
    refChk(rvr_pkg::MODE_PARALLEL, rvr_pkg::OP_NORMAL, 9'h1f0, 9'h080);
    refChk(rvr_pkg::MODE_PARALLEL, rvr_pkg::OP_NORMAL, 9'h000, 9'h008);
    $display("reference test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    alertSrc = 4'h0;
    alertPinFunctionSelect = 1'b0;
    reportFormatSel = 2'b00;
    vidRes10mV = 1'b0;
    diffHalfGain = 1'b0;
    extDividerEn = 1'b0;
    railMode = rvr_pkg::MODE_BUS;
    marginSel = rvr_pkg::OP_NORMAL;
    serialVid = 9'h000;
    parallelVid = 9'h000;
    avsVid = 9'h000;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    testRegs();
    testFormat();
    testAlert();
    testRef();
    completeRun();
  end
  // The tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    completeRun();
  end
endmodule
`default_nettype wire
